//--- hdl/dbsd_regs.sv
// Back-end service, PHY access, FIFO error and decode registers
`timescale 1ns/1ps
`default_nettype none

module dbsd_regs
    import dbsd_pkg::*;
#(
    parameter int unsigned N_PORTS = 4,
    parameter logic [NFIFO-1:0] FIFO_ECC = 8'hFF,
    parameter int unsigned CTRL_BITS = 32,
    parameter bit PHY_RDERR = 1'b1
) (
    input wire logic i_clock,
    input wire logic i_reset,
    // Register access port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Correction engine
    input wire logic i_internal_err,
    input wire logic i_rd_word,
    output logic [1:0] o_correction_mode,
    output logic o_auto_retry,
    output logic o_rmw_disable,
    output logic o_retry_req,
    output logic o_test_err,
    // PHY read errors
    input wire logic [LANES-1:0] i_phy_rd_err,
    input wire logic [LANES-1:0] i_lane_disable,
    output logic [LANES-1:0] o_lane_fail,
    // PHY indirect access and generic control
    output logic [7:0] o_phy_ind_addr,
    output logic o_phy_ind_wr,
    output logic o_phy_ind_rd,
    output logic [31:0] o_phy_ind_wdata,
    input wire logic [31:0] i_phy_ind_rdata,
    output logic [31:0] o_phy_generic_ctrl,
    // Service timing
    input wire logic [11:0] i_service_interval,
    output logic o_service_tick,
    output logic o_ten_ms_tick,
    // FIFO error events, even index write data, odd index command
    input wire logic [NFIFO-1:0] i_fifo_ce,
    input wire logic [NFIFO-1:0] i_fifo_ue,
    // System address decode
    input wire logic i_sys_valid,
    input wire logic [31:0] i_sys_addr,
    output logic o_bus_err,
    output logic [2:0] o_rank_count,
    output logic [3:0] o_rank_select_bits,
    output logic [3:0] o_bank_select_bits,
    output logic [2:0] o_row_select_bits,
    output logic [1:0] o_col_select_bits
);
    // Implemented generic control bits
    localparam logic [31:0] GEN_MASK = 32'hFFFF_FFFF >> (32 - CTRL_BITS);

    logic wr_corr;
    logic wr_ind_addr;
    logic wr_ind_data;
    logic wr_gen;
    logic wr_fifo;
    logic wr_dec;
    logic [4:0] corr_ff;
    logic arm_ff;
    logic [2:0] cnt_ff;
    logic fire;
    logic test_err_ff;
    logic retry_ff;
    logic [LANES-1:0] rd_err_ff;
    logic [LANES-1:0] lane_fail_ff;
    logic [7:0] ind_addr_ff;
    logic ind_wr_ff;
    logic [31:0] ind_wdata_ff;
    logic [31:0] gen_ff;
    logic [31:0] dec_ff;
    logic bus_err_ff;
    logic nxt_bus_err;
    logic [31:0] fifo_word;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic rvalid_ff;
    logic [4:0] shift;

    dbsd_svc_if svc ();

    // ==========================================
    // Address decode of writes
    assign wr_corr = i_reg_wr && (i_reg_addr == OFF_CORR);
    assign wr_ind_addr = i_reg_wr && (i_reg_addr == OFF_IND_ADDR);
    assign wr_ind_data = i_reg_wr && (i_reg_addr == OFF_IND_DATA);
    assign wr_gen = i_reg_wr && (i_reg_addr == OFF_GEN);
    assign wr_fifo = i_reg_wr && (i_reg_addr == OFF_FIFO);
    assign wr_dec = i_reg_wr && (i_reg_addr == OFF_DEC);

    // ==========================================
    // Correction configuration
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            corr_ff <= CORR_RESET;
        end else if (wr_corr) begin
            corr_ff <= i_reg_wdata[31:27];
        end
    end

    assign o_correction_mode = corr_ff[4:3];
    assign o_auto_retry = corr_ff[CORR_RETRY - 27];
    assign o_rmw_disable = corr_ff[CORR_NORMW - 27];

    // Retry self test fires once after the programmed word count
    assign fire = arm_ff && i_rd_word && (cnt_ff == 3'h1) && !wr_corr;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            arm_ff <= 1'b0;
            cnt_ff <= 3'h0;
        end else if (wr_corr) begin
            if (i_reg_wdata[CORR_ARM] && (i_reg_wdata[2:0] != 3'h0)) begin
                arm_ff <= 1'b1;
                cnt_ff <= i_reg_wdata[2:0];
            end else begin
                arm_ff <= 1'b0;
                cnt_ff <= 3'h0;
            end
        end else if (fire) begin
            arm_ff <= 1'b0;
            cnt_ff <= 3'h0;
        end else if (arm_ff && i_rd_word) begin
            cnt_ff <= cnt_ff - 3'h1;
        end
    end

    // Internal error flag and retry request
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            test_err_ff <= 1'b0;
            retry_ff <= 1'b0;
        end else begin
            test_err_ff <= fire;
            retry_ff <= o_auto_retry && (i_internal_err || fire);
        end
    end

    assign o_test_err = test_err_ff;
    assign o_retry_req = retry_ff;

    // ==========================================
    // PHY read error status and lane failure messages
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rd_err_ff <= '0;
            lane_fail_ff <= '0;
        end else begin
            rd_err_ff <= (rd_err_ff | i_phy_rd_err) & ~i_lane_disable;
            if (PHY_RDERR && corr_ff[CORR_RDERR - 27]) begin
                lane_fail_ff <= i_phy_rd_err;
            end else begin
                lane_fail_ff <= '0;
            end
        end
    end

    assign o_lane_fail = lane_fail_ff;

    // ==========================================
    // PHY indirect access and generic control
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ind_addr_ff <= 8'h00;
        end else if (wr_ind_addr) begin
            ind_addr_ff <= i_reg_wdata[7:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ind_wr_ff <= 1'b0;
            ind_wdata_ff <= 32'h0000_0000;
        end else begin
            ind_wr_ff <= wr_ind_data;
            if (wr_ind_data) begin
                ind_wdata_ff <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            gen_ff <= 32'h0000_0000;
        end else if (wr_gen) begin
            gen_ff <= i_reg_wdata & GEN_MASK;
        end
    end

    assign o_phy_ind_addr = ind_addr_ff;
    assign o_phy_ind_wr = ind_wr_ff;
    assign o_phy_ind_wdata = ind_wdata_ff;
    assign o_phy_ind_rd = i_reg_rd && (i_reg_addr == OFF_IND_DATA);
    assign o_phy_generic_ctrl = gen_ff;

    // ==========================================
    // Service and training counters
    assign svc.wr_svc = i_reg_wr && (i_reg_addr == OFF_SVC);
    assign svc.wr_trn = i_reg_wr && (i_reg_addr == OFF_TRN);
    assign svc.wdata = i_reg_wdata;
    assign svc.interval = i_service_interval;
    assign o_service_tick = svc.svc_word[SVC_TICK];
    assign o_ten_ms_tick = svc.trn_word[TRN_TICK];

    dbsd_svc_timer u_timer (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .bus(svc.tmr)
    );

    // ==========================================
    // FIFO error counters, kept through reset
    assign fifo_word[31:3*NFIFO] = '0;

    for (genvar k = 0; k < NFIFO; k++) begin : g_fifo
        if ((k < 2 * N_PORTS) && FIFO_ECC[k]) begin : g_on
            logic [1:0] ce_ff;
            logic ue_ff;
            logic [1:0] ce_kept;
            assign ce_kept = wr_fifo ? ce_ff & ~i_reg_wdata[3*k +: 2] : ce_ff;
            // A clear applies first, a count in the same cycle then adds one
            always_ff @(posedge i_clock) begin
                if (i_fifo_ce[k] && ce_kept != 2'h3) begin
                    ce_ff <= ce_kept + 2'h1;
                end else begin
                    ce_ff <= ce_kept;
                end
            end
            always_ff @(posedge i_clock) begin
                if (i_fifo_ue[k]) begin
                    ue_ff <= 1'b1;
                end else if (wr_fifo && i_reg_wdata[3*k+2]) begin
                    ue_ff <= 1'b0;
                end
            end
            assign fifo_word[3*k +: 3] = {ue_ff, ce_ff};
            a_fifo_ue_sticky: assert property (@(posedge i_clock)
                (ue_ff && !(wr_fifo && i_reg_wdata[3*k+2])) |=> ue_ff)
                else $error("fifo uncorrectable flag lost");
        end else begin : g_off
            assign fifo_word[3*k +: 3] = 3'h0;
        end
    end

    // ==========================================
    // System address decode and out-of-range check
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            dec_ff <= DEC_RESET;
        end else if (wr_dec) begin
            dec_ff <= i_reg_wdata & DEC_WMASK;
        end
    end

    assign o_rank_count = dec_ff[DEC_RANKS_LSB +: 3];
    assign o_rank_select_bits = dec_ff[DEC_RANK_LSB +: 4];
    assign o_bank_select_bits = dec_ff[DEC_BANK_LSB +: 4];
    assign o_row_select_bits = dec_ff[DEC_ROW_LSB +: 3];
    assign o_col_select_bits = dec_ff[1:0];
    assign shift = {1'b0, o_rank_select_bits} + RANK_BASE_BIT;

    // Rank field above the rank count means no memory there
    always_comb begin
        nxt_bus_err = 1'b0;
        if (dec_ff[DEC_OOR] && i_sys_valid && o_rank_select_bits < RANK_ALL_FIRST) begin
            nxt_bus_err = (i_sys_addr >> shift) > {29'h0, o_rank_count};
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            bus_err_ff <= 1'b0;
        end else begin
            bus_err_ff <= nxt_bus_err;
        end
    end

    assign o_bus_err = bus_err_ff;

    // ==========================================
    // Read data return
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (i_reg_addr)
            OFF_CORR: nxt_rdata = {corr_ff, 23'h0, arm_ff, cnt_ff};
            OFF_SVC: nxt_rdata = svc.svc_word;
            OFF_IND_ADDR: nxt_rdata = {rd_err_ff, 12'h000, ind_addr_ff};
            OFF_IND_DATA: nxt_rdata = i_phy_ind_rdata;
            OFF_GEN: nxt_rdata = gen_ff;
            OFF_TRN: nxt_rdata = svc.trn_word;
            OFF_FIFO: nxt_rdata = fifo_word;
            OFF_DEC: nxt_rdata = dec_ff;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rdata_ff <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= i_reg_rd;
            if (i_reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_reg_rvalid = rvalid_ff;

    // ==========================================
    // Checks
    a_test_fires: assert property (@(posedge i_clock) disable iff (i_reset)
        (arm_ff && cnt_ff == 3'h1 && i_rd_word && !wr_corr)
        |=> (o_test_err && !arm_ff))
        else $error("retry test did not fire on last word");
    a_test_cleared: assert property (@(posedge i_clock) disable iff (i_reset)
        (wr_corr && (!i_reg_wdata[CORR_ARM] || i_reg_wdata[2:0] == 3'h0))
        |=> (!arm_ff && cnt_ff == 3'h0))
        else $error("disarmed retry test not cleared");
    a_test_quiet: assert property (@(posedge i_clock) disable iff (i_reset)
        !arm_ff |=> !o_test_err)
        else $error("test error without arming");
    a_retry_req: assert property (@(posedge i_clock) disable iff (i_reset)
        (o_auto_retry && i_internal_err) |=> o_retry_req)
        else $error("internal error did not request retry");
    a_lane_clear: assert property (@(posedge i_clock) disable iff (i_reset)
        ##1 (rd_err_ff & $past(i_lane_disable)) == '0)
        else $error("disabled lane kept read error");
    a_lane_fail: assert property (@(posedge i_clock) disable iff (i_reset)
        !corr_ff[CORR_RDERR - 27] |=> o_lane_fail == '0)
        else $error("lane failure while read error disabled");
    a_bus_err_off: assert property (@(posedge i_clock) disable iff (i_reset)
        (!dec_ff[DEC_OOR] || o_rank_select_bits == RANK_ALL_FIRST)
        |=> !o_bus_err)
        else $error("bus error while range check off");
endmodule : dbsd_regs

`default_nettype wire

//--- include/dbsd_pkg.sv
// Constants and register map of the DDR back-end service and decode block
package dbsd_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned LANES = 12;
    localparam int unsigned NFIFO = 8;
    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_CORR = 12'h070;
    localparam logic [ADDR_W-1:0] OFF_SVC = 12'h074;
    localparam logic [ADDR_W-1:0] OFF_IND_ADDR = 12'h078;
    localparam logic [ADDR_W-1:0] OFF_IND_DATA = 12'h07C;
    localparam logic [ADDR_W-1:0] OFF_GEN = 12'h080;
    localparam logic [ADDR_W-1:0] OFF_TRN = 12'h084;
    localparam logic [ADDR_W-1:0] OFF_FIFO = 12'h088;
    localparam logic [ADDR_W-1:0] OFF_DEC = 12'h200;
    // Correction configuration fields
    localparam int unsigned CORR_MODE_LSB = 30;
    localparam int unsigned CORR_RETRY = 29;
    localparam int unsigned CORR_RDERR = 28;
    localparam int unsigned CORR_NORMW = 27;
    localparam int unsigned CORR_ARM = 3;
    localparam logic [4:0] CORR_RESET = 5'h10;
    localparam logic [1:0] MODE_FULL = 2'h2;
    localparam logic [1:0] MODE_PARITY = 2'h1;
    localparam logic [1:0] MODE_NONE = 2'h0;
    // Service and training counter fields
    localparam int unsigned SVC_TICK = 28;
    localparam int unsigned SVC_MR_LSB = 20;
    localparam int unsigned SVC_REF_LSB = 12;
    localparam int unsigned TRN_FULL_LSB = 24;
    localparam int unsigned TRN_PER_LSB = 16;
    localparam int unsigned TRN_TICK = 15;
    localparam int unsigned TRN_M10_LSB = 8;
    localparam int unsigned IND_ERR_LSB = 20;
    // Address decode fields
    localparam int unsigned DEC_OOR = 31;
    localparam int unsigned DEC_RANKS_LSB = 13;
    localparam int unsigned DEC_RANK_LSB = 9;
    localparam int unsigned DEC_BANK_LSB = 5;
    localparam int unsigned DEC_ROW_LSB = 2;
    localparam logic [31:0] DEC_RESET = 32'h0000_E6AA;
    localparam logic [31:0] DEC_WMASK = 32'h8000_FFFF;
    localparam logic [3:0] RANK_ALL_FIRST = 4'hA;
    localparam logic [4:0] RANK_BASE_BIT = 5'h16;
endpackage : dbsd_pkg

//--- include/dbsd_svc_if.sv
// Carrier between register block and service timer
`timescale 1ns/1ps
`default_nettype none

interface dbsd_svc_if;
    logic wr_svc;
    logic wr_trn;
    logic [31:0] wdata;
    logic [11:0] interval;
    logic [31:0] svc_word;
    logic [31:0] trn_word;
    modport ctl (output wr_svc, wr_trn, wdata, interval,
                 input svc_word, trn_word);
    modport tmr (input wr_svc, wr_trn, wdata, interval,
                 output svc_word, trn_word);
endinterface : dbsd_svc_if

`default_nettype wire

//--- hdl/dbsd_svc_timer.sv
// Service and training time counters of the back-end
`timescale 1ns/1ps
`default_nettype none

module dbsd_svc_timer
    import dbsd_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    dbsd_svc_if.tmr bus
);
    logic [11:0] si_ff;
    logic tick_ff;
    logic [7:0] mr_ff;
    logic [7:0] ref_ff;
    logic [7:0] u100_ff;
    logic [6:0] m10_ff;
    logic t10_ff;
    logic [7:0] ftr_ff;
    logic [7:0] itr_ff;
    logic u_wrap;
    logic m_wrap;

    // ==========================================
    // Service interval
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            si_ff <= 12'h000;
            tick_ff <= 1'b0;
        end else if (bus.wr_svc) begin
            si_ff <= bus.wdata[11:0];
            tick_ff <= bus.wdata[SVC_TICK];
        end else if (si_ff == 12'h000) begin
            si_ff <= bus.interval;
            tick_ff <= 1'b1;
        end else begin
            si_ff <= si_ff - 12'h001;
            tick_ff <= 1'b0;
        end
    end

    // Mode reprogram and refresh counts step on tick
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            mr_ff <= 8'h00;
            ref_ff <= 8'h00;
        end else if (bus.wr_svc) begin
            mr_ff <= bus.wdata[SVC_MR_LSB +: 8];
            ref_ff <= bus.wdata[SVC_REF_LSB +: 8];
        end else if (tick_ff) begin
            mr_ff <= mr_ff - 8'h01;
            ref_ff <= ref_ff - 8'h01;
        end
    end

    // ==========================================
    // Training time base
    assign u_wrap = tick_ff && (u100_ff == 8'h00);
    assign m_wrap = u_wrap && (m10_ff == 7'h00);

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            u100_ff <= 8'h00;
            m10_ff <= 7'h00;
            t10_ff <= 1'b0;
        end else if (bus.wr_trn) begin
            u100_ff <= bus.wdata[7:0];
            m10_ff <= bus.wdata[TRN_M10_LSB +: 7];
            t10_ff <= bus.wdata[TRN_TICK];
        end else begin
            if (tick_ff) begin
                u100_ff <= u100_ff - 8'h01;
            end
            if (u_wrap) begin
                m10_ff <= m10_ff - 7'h01;
            end
            t10_ff <= m_wrap;
        end
    end

    // Training counts step on the 10 ms tick
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ftr_ff <= 8'h00;
            itr_ff <= 8'h00;
        end else if (bus.wr_trn) begin
            ftr_ff <= bus.wdata[TRN_FULL_LSB +: 8];
            itr_ff <= bus.wdata[TRN_PER_LSB +: 8];
        end else if (t10_ff) begin
            ftr_ff <= ftr_ff - 8'h01;
            itr_ff <= itr_ff - 8'h01;
        end
    end

    assign bus.svc_word = {3'h0, tick_ff, mr_ff, ref_ff, si_ff};
    assign bus.trn_word = {ftr_ff, itr_ff, t10_ff, m10_ff, u100_ff};

    // ==========================================
    // Checks
    a_interval_reload: assert property (@(posedge i_clock) disable iff (i_reset)
        (si_ff == 12'h000 && !bus.wr_svc)
        |=> (si_ff == $past(bus.interval) && tick_ff))
        else $error("interval count did not reload with tick");
    a_interval_step: assert property (@(posedge i_clock) disable iff (i_reset)
        (si_ff != 12'h000 && !bus.wr_svc)
        |=> (si_ff == $past(si_ff) - 12'h001 && !tick_ff))
        else $error("interval count did not decrement");
    a_refresh_hold: assert property (@(posedge i_clock) disable iff (i_reset)
        (!tick_ff && !bus.wr_svc) |=> $stable(ref_ff) && $stable(mr_ff))
        else $error("refresh count moved without tick");
    a_ten_ms_once: assert property (@(posedge i_clock) disable iff (i_reset)
        (t10_ff && !bus.wr_trn) |=> !t10_ff)
        else $error("ten ms tick longer than one cycle");
    a_training_step: assert property (@(posedge i_clock) disable iff (i_reset)
        (t10_ff && !bus.wr_trn) |=> ftr_ff == $past(ftr_ff) - 8'h01)
        else $error("training count not stepped on tick");
endmodule : dbsd_svc_timer

`default_nettype wire

//--- test/dbsd_phy_model.sv
// PHY register file model behind the indirect access path
`timescale 1ns/1ps
`default_nettype none

module dbsd_phy_model (
    input wire logic i_clock,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata
);
    logic [31:0] mem_ff [256];
    // Store writes at the selected register
    always_ff @(posedge i_clock) begin
        if (i_wr) begin
            mem_ff[i_addr] <= i_wdata;
        end
    end
    // Data only valid while the read strobe is high
    assign o_rdata = i_rd ? mem_ff[i_addr] : ~mem_ff[i_addr];
endmodule : dbsd_phy_model

`default_nettype wire

//--- test/ddr_backend_service_decode_regs_tb.sv
// Self-checking bench of the back-end service and decode registers
`timescale 1ns/1ps
`default_nettype none

module ddr_backend_service_decode_regs_tb
    import dbsd_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rdw = 1'b0;
    logic sys_v = 1'b0, rvalid, retry, terr, iwr, ird, aretry, rmwd;
    logic stick, ttick, berr, ierr = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0, sys_a = '0, rdata, gen, iwd, ipd, v, e, f;
    logic [LANES-1:0] rderr = '0, ldis = '0, lfail, lm;
    logic [7:0] iaddr, ce = '0, ue = '0;
    logic [1:0] mode, colb;
    logic [2:0] nrk, rowb;
    logic [3:0] rsel, bsel;
    int seed = 48819, fail_count = 0, checked = 0, n;
    int cnt [8];

    always #2.5 clk = ~clk;

    dbsd_regs i_dut (.i_clock(clk), .i_reset(rst), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_internal_err(ierr),
        .i_rd_word(rdw), .o_correction_mode(mode), .o_auto_retry(aretry),
        .o_rmw_disable(rmwd), .o_retry_req(retry), .o_test_err(terr),
        .i_phy_rd_err(rderr), .i_lane_disable(ldis), .o_lane_fail(lfail),
        .o_phy_ind_addr(iaddr), .o_phy_ind_wr(iwr), .o_phy_ind_rd(ird),
        .o_phy_ind_wdata(iwd), .i_phy_ind_rdata(ipd),
        .o_phy_generic_ctrl(gen), .i_service_interval(12'h003),
        .o_service_tick(stick), .o_ten_ms_tick(ttick), .i_fifo_ce(ce),
        .i_fifo_ue(ue), .i_sys_valid(sys_v), .i_sys_addr(sys_a),
        .o_bus_err(berr), .o_rank_count(nrk), .o_rank_select_bits(rsel),
        .o_bank_select_bits(bsel), .o_row_select_bits(rowb),
        .o_col_select_bits(colb));
    dbsd_phy_model i_phy (.i_clock(clk), .i_addr(iaddr), .i_wr(iwr),
        .i_rd(ird), .i_wdata(iwd), .o_rdata(ipd));

    // ==========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] ex, got);
        checked++;
        if (got !== ex) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic acc(input bit w, input logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 v = rdata;
        if (!w) chk("rvalid", 1, rvalid);
    endtask : acc
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    task automatic wait_hi(ref logic s);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (s !== 1'b1 && n < 200);
        if (n >= 200) begin
            fail_count++;
            print_verdict();
        end
    endtask : wait_hi
    // Expected FIFO error word from event counts and flags
    function automatic logic [31:0] fexp(input logic [7:0] u);
        fexp = '0;
        for (int q = 0; q < 8; q++) begin
            fexp[q*3 +: 2] = cnt[q] > 3 ? 2'h3 : 2'(cnt[q]);
            fexp[q*3+2] = u[q];
        end
    endfunction : fexp

    // ==========================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        acc(0, OFF_DEC, 0);
        chk("decode", DEC_RESET, {nrk, rsel, bsel, rowb, colb});
        chk("dec_reg", DEC_RESET, v);
        chk("mode", MODE_FULL, mode);
        for (int i = 0; i < 8; i++) begin
            // Masked writes only requested with correction off
            acc(1, OFF_CORR, {i[0] ? 2'h0 : 2'h2, i[2:0], 27'h0});
            chk("flags", {i[2], i[0]}, {aretry, rmwd});
            chk("mode", i[0] ? MODE_NONE : MODE_FULL, mode);
            lm = 12'($random(seed));
            @(posedge clk);
            rderr <= lm;
            ierr <= 1'b1;
            @(posedge clk);
            rderr <= '0;
            ierr <= 1'b0;
            #1 chk("lane_fail", i[1] ? lm : 12'h0, lfail);
            chk("retry", i[2], retry);
        end
        ldis <= '1;
        acc(0, OFF_IND_ADDR, 0);
        ldis <= '0;
        lm = 12'($random(seed));
        rderr <= lm;
        acc(0, OFF_IND_ADDR, 0);
        rderr <= '0;
        chk("lane_err", lm, v[31:20]);
        ldis <= lm;
        acc(0, OFF_IND_ADDR, 0);
        chk("lane_clr", 0, v[31:20]);
        // Indirect PHY access, generic control
        for (int i = 0; i < 4; i++) begin
            e = $random(seed);
            acc(1, OFF_IND_ADDR, i * 37);
            acc(1, OFF_IND_DATA, e);
            acc(1, OFF_IND_ADDR, i * 37 + 1);
            acc(1, OFF_IND_DATA, ~e);
            acc(1, OFF_IND_ADDR, i * 37);
            chk("ind_addr", i * 37, iaddr);
            acc(0, OFF_IND_DATA, 0);
            chk("ind_data", e, v);
            acc(1, OFF_GEN, ~e);
            chk("gen_ctrl", ~e, gen);
        end
        // Retry test, every count
        for (int k = 1; k < 8; k++) begin
            acc(1, OFF_CORR, 32'hA000_0008 | k);
            repeat (k) begin
                @(posedge clk);
                rdw <= 1'b1;
            end
            @(posedge clk);
            rdw <= 1'b0;
            #1 chk("test_err", 2'h3, {terr, retry});
            acc(1, OFF_CORR, k == 7 ? 32'h8000_0008 : 32'h8000_0005);
            acc(0, OFF_CORR, 0);
            chk("test_idle", 0, v[3:0]);
        end
        // Service and training counters
        wait_hi(stick);
        wait_hi(stick);
        chk("tick_gap", 4, n);
        acc(0, OFF_SVC, 0);
        e = v;
        acc(0, OFF_TRN, 0);
        f = v;
        repeat (12) @(posedge clk);
        acc(0, OFF_SVC, 0);
        chk("svc", {e[28], e[27:20] - 8'h4, e[19:12] - 8'h4, e[11:0]},
            v[28:0]);
        acc(0, OFF_TRN, 0);
        chk("u100", 8'(f[7:0] - 8'h4), v[7:0]);
        acc(1, OFF_TRN, 32'h5A3C_0001);
        wait_hi(ttick);
        @(posedge clk);
        #1 chk("ten_ms_tick", 0, ttick);
        acc(0, OFF_TRN, 0);
        chk("train", 24'h593B7F, v[31:8]);
        // FIFO error counters
        acc(1, OFF_FIFO, 32'h00FF_FFFF);
        for (int j = 0; j < 8; j++) cnt[j] = $random(seed) & 7;
        f = $random(seed);
        ue <= f[7:0];
        for (int j = 0; j < 7; j++) begin
            @(posedge clk);
            ue <= '0;
            for (int q = 0; q < 8; q++) ce[q] <= cnt[q] > j;
        end
        @(posedge clk);
        ce <= '0;
        acc(0, OFF_FIFO, 0);
        chk("fifo", fexp(f[7:0]), v);
        acc(1, OFF_FIFO, v);
        acc(0, OFF_FIFO, 0);
        chk("fifo_clr", 0, v);
        // Out-of-range check, decoded and all-first-rank
        for (int s = 0; s < 2; s++) begin
            acc(1, OFF_DEC, 32'h8000_2000 | (s * 32'h1400));
            for (int i = 0; i < 4; i++) begin
                @(posedge clk);
                sys_v <= 1'b1;
                sys_a <= {i[9:0], 22'($random(seed))};
                @(posedge clk);
                sys_v <= 1'b0;
                #1 chk("bus_err", i > 1 && s == 0, berr);
            end
        end
        acc(0, 12'h100, 0);
        chk("unmapped", 0, v);
        print_verdict();
    end
endmodule : ddr_backend_service_decode_regs_tb

`default_nettype wire
